/* File: hdl/sop_defines.svh */
// register offsets, field positions, reset values and timing counts for the system options bank
`ifndef SOP_DEFINES_SVH
`define SOP_DEFINES_SVH

// byte addresses on the wishbone bus
`define SOP_OPT_ONE_ADDR       8'h00
`define SOP_OPT_TWO_ADDR       8'h04
`define SOP_ID_HIGH_ADDR       8'h08
`define SOP_ID_LOW_ADDR        8'h0c

// options-two field positions
`define SOP_WDOG_CLK_BIT       7
`define SOP_TRIG_SEL_BIT       3
`define SOP_SPI_PLACE_BIT      2
`define SOP_I2C_PLACE_BIT      1
`define SOP_CMP_LINK_BIT       0
`define SOP_OPT_TWO_MASK       8'h8f

// options-one field position
`define SOP_WDOG_TMO_BIT       6

// reset values
`define SOP_OPT_ONE_RESET      8'h00
`define SOP_OPT_TWO_RESET      8'h00

// part number, arbitrary value
`define SOP_PART_NUMBER        12'h5a3

// watchdog timeout counts in source-clock cycles
`define SOP_WDOG_SHORT_CYCLES  18'h00020
`define SOP_WDOG_LONG_CYCLES   18'h00100

`endif

/* File: hdl/sop_once_bit.sv */
// write-once register bit: first write after reset is taken, later ones ignored
`timescale 1ns/1ps
`default_nettype none
module sop_once_bit #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic wr_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic q;
    logic done;
    logic next_q;
    logic next_done;

    // lock after the first write
    always_comb
    begin
        next_q    = q;
        next_done = done;
        if (wr_i && !done)
        begin
            next_q    = d_i;
            next_done = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q    <= RESET_VALUE;
            done <= 1'b0;
        end
        else
        begin
            q    <= next_q;
            done <= next_done;
        end
    end

    assign q_o = q;
endmodule : sop_once_bit
`default_nettype wire

/* File: hdl/sop_pin_mux.sv */
// registered routing of the spi and two-wire ports to port a/b pins
`timescale 1ns/1ps
`default_nettype none
module sop_pin_mux
    import sop_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire sop_route_type route_i,
    input  wire logic          spi_mosi_i,
    input  wire logic          spi_sck_i,
    input  wire logic          spi_ss_i,
    input  wire logic          i2c_sda_i,
    input  wire logic          i2c_scl_i,
    output logic [3:0]         port_a_o,
    output logic [7:4]         port_b_o,
    output logic [3:0]         port_a_fn_o,
    output logic [7:4]         port_b_fn_o
);
    logic [3:0] next_port_a;
    logic [7:4] next_port_b;
    logic [3:0] next_fn_a;
    logic [7:4] next_fn_b;

    // pin placement; miso pin is marked as owned but driven by the far side
    always_comb
    begin
        next_port_a = 4'h0;
        next_port_b = 4'h0;
        next_fn_a   = 4'h0;
        next_fn_b   = 4'h0;
        if (route_i.spi_on_port_b)
        begin
            next_port_b[5] = spi_mosi_i;
            next_port_b[6] = spi_sck_i;
            next_port_b[7] = spi_ss_i;
            next_fn_b      = next_fn_b | 4'hf;
        end
        else
        begin
            next_port_a[3] = spi_mosi_i;
            next_port_a[1] = spi_sck_i;
            next_port_a[0] = spi_ss_i;
            next_fn_a      = next_fn_a | 4'hf;
        end
        if (route_i.i2c_on_port_a)
        begin
            next_port_a[2] = i2c_sda_i;
            next_port_a[3] = i2c_scl_i;
            next_fn_a[3:2] = 2'h3;
        end
        else
        begin
            next_port_b[4] = i2c_sda_i;
            next_port_b[5] = i2c_scl_i;
            next_fn_b[5:4] = 2'h3;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            port_a_o    <= 4'h0;
            port_b_o    <= 4'h0;
            port_a_fn_o <= 4'h0;
            port_b_fn_o <= 4'h0;
        end
        else
        begin
            port_a_o    <= next_port_a;
            port_b_o    <= next_port_b;
            port_a_fn_o <= next_fn_a;
            port_b_fn_o <= next_fn_b;
        end
    end
endmodule : sop_pin_mux
`default_nettype wire

/* File: hdl/sop_pkg.sv */
// types shared by the system options bank
package sop_pkg;

    // pin routing carried to the port muxes
    typedef struct packed {
        logic spi_on_port_b;
        logic i2c_on_port_a;
        logic cmp_to_capture;
        logic trig_from_timer;
    } sop_route_type;

    // bus cycle states
    typedef enum logic [1:0] {
        SOP_IDLE,
        SOP_ACK
    } sop_bus_state_type;

endpackage : sop_pkg

/* File: hdl/sop_regs.sv */
// system options and part identification registers on a classic wishbone slave
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sop_defines.svh"

module sop_regs
    import sop_pkg::*;
#(
    parameter int          ADDR_W      = 8,
    parameter logic [11:0] PART_NUMBER = `SOP_PART_NUMBER
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic [31:0]            dat_o,
    output logic                   ack_o,
    output logic                   err_o,
    input  wire logic              tod_match_i,
    input  wire logic              timer2_ovf_i,
    input  wire logic              cmp_out_i,
    input  wire logic              cap_pin_i,
    input  wire logic              spi_mosi_i,
    input  wire logic              spi_sck_i,
    input  wire logic              spi_ss_i,
    input  wire logic              i2c_sda_i,
    input  wire logic              i2c_scl_i,
    output logic                   wdog_use_bus_clk_o,
    output logic [17:0]            wdog_period_o,
    output logic                   conv_hw_trigger_o,
    output logic                   timer2_cap0_o,
    output logic [3:0]             port_a_o,
    output logic [7:4]             port_b_o,
    output logic [3:0]             port_a_fn_o,
    output logic [7:4]             port_b_fn_o
);
    // the decode needs every bit of the highest offset
    if (ADDR_W < 4 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("sop_regs: ADDR_W out of range");
    end

    sop_bus_state_type state;
    sop_bus_state_type next_state;
    logic [31:0]       next_dat;
    logic              next_ack;
    logic              next_err;
    logic              wr_lane0;
    logic              hit_one;
    logic              hit_two;
    logic              hit_idh;
    logic              hit_idl;
    logic [3:0]        opt_two_lo;
    logic [3:0]        next_opt_two_lo;
    logic              wdog_clk;
    logic              wdog_tmo;
    logic [7:0]        opt_two_rd;
    sop_route_type     route;

    // address decode, low two address bits ignored for word alignment
    assign hit_one  = adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`SOP_OPT_ONE_ADDR >> 2);
    assign hit_two  = adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`SOP_OPT_TWO_ADDR >> 2);
    assign hit_idh  = adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`SOP_ID_HIGH_ADDR >> 2);
    assign hit_idl  = adr_i[ADDR_W-1:2] == (ADDR_W-2)'(`SOP_ID_LOW_ADDR >> 2);
    // a write lands only on the cycle that is acknowledged
    assign wr_lane0 = cyc_i && stb_i && we_i && sel_i[0] && state == SOP_IDLE;

    // watchdog clock select, locked after first write
    sop_once_bit #(
        .RESET_VALUE (1'b0)
    ) u_wdog_clk (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .wr_i  (wr_lane0 && hit_two),
        .d_i   (dat_i[`SOP_WDOG_CLK_BIT]),
        .q_o   (wdog_clk)
    );

    // timeout select held in options one, also write-once
    sop_once_bit #(
        .RESET_VALUE (1'b0)
    ) u_wdog_tmo (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .wr_i  (wr_lane0 && hit_one),
        .d_i   (dat_i[`SOP_WDOG_TMO_BIT]),
        .q_o   (wdog_tmo)
    );

    // freely writable options bits
    always_comb
    begin
        next_opt_two_lo = opt_two_lo;
        if (wr_lane0 && hit_two)
            next_opt_two_lo = dat_i[3:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            opt_two_lo <= 4'(`SOP_OPT_TWO_RESET);
        else
            opt_two_lo <= next_opt_two_lo;
    end

    // bits 6:4 are tied zero on read
    assign opt_two_rd = {wdog_clk, 3'h0, opt_two_lo};

    // single-cycle answer, ack dropped the cycle after
    always_comb
    begin
        next_state = SOP_IDLE;
        next_ack   = 1'b0;
        next_err   = 1'b0;
        next_dat   = 32'h0;
        case (state)
            SOP_IDLE:
            begin
                if (cyc_i && stb_i)
                begin
                    next_state = SOP_ACK;
                    if (hit_one)
                    begin
                        next_ack = 1'b1;
                        next_dat = {24'h0, 1'b0, wdog_tmo, 6'h0};
                    end
                    else if (hit_two)
                    begin
                        next_ack = 1'b1;
                        next_dat = {24'h0, opt_two_rd};
                    end
                    else if (hit_idh)
                    begin
                        next_ack = 1'b1;
                        next_dat = {24'h0, 4'h0, PART_NUMBER[11:8]};
                    end
                    else if (hit_idl)
                    begin
                        next_ack = 1'b1;
                        next_dat = {24'h0, PART_NUMBER[7:0]};
                    end
                    else
                        next_err = 1'b1;
                end
            end
            SOP_ACK:
                next_state = SOP_IDLE;
            default:
                next_state = SOP_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= SOP_IDLE;
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0;
        end
        else
        begin
            state <= next_state;
            ack_o <= next_ack;
            err_o <= next_err;
            dat_o <= next_dat;
        end
    end

    assign route.spi_on_port_b   = opt_two_lo[`SOP_SPI_PLACE_BIT];
    assign route.i2c_on_port_a   = opt_two_lo[`SOP_I2C_PLACE_BIT];
    assign route.cmp_to_capture  = opt_two_lo[`SOP_CMP_LINK_BIT];
    assign route.trig_from_timer = opt_two_lo[`SOP_TRIG_SEL_BIT];

    // registered outputs to the watchdog, converter and timer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wdog_use_bus_clk_o <= 1'b0;
            wdog_period_o      <= `SOP_WDOG_SHORT_CYCLES;
            conv_hw_trigger_o  <= 1'b0;
            timer2_cap0_o      <= 1'b0;
        end
        else
        begin
            wdog_use_bus_clk_o <= wdog_clk;
            // period counts in whichever clock is selected
            wdog_period_o      <= wdog_tmo ? `SOP_WDOG_LONG_CYCLES
                                           : `SOP_WDOG_SHORT_CYCLES;
            conv_hw_trigger_o  <= route.trig_from_timer ? timer2_ovf_i
                                                        : tod_match_i;
            // with link off the capture pin drives channel 0 as usual
            timer2_cap0_o      <= route.cmp_to_capture ? cmp_out_i : cap_pin_i;
        end
    end

    sop_pin_mux u_pin_mux (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .route_i     (route),
        .spi_mosi_i  (spi_mosi_i),
        .spi_sck_i   (spi_sck_i),
        .spi_ss_i    (spi_ss_i),
        .i2c_sda_i   (i2c_sda_i),
        .i2c_scl_i   (i2c_scl_i),
        .port_a_o    (port_a_o),
        .port_b_o    (port_b_o),
        .port_a_fn_o (port_a_fn_o),
        .port_b_fn_o (port_b_fn_o)
    );

    // assertions
    property p_once;
        @(posedge clk_i) disable iff (rst_i)
        wr_lane0 && hit_two && u_wdog_clk.done |=> $stable(wdog_clk);
    endproperty
    a_once: assert property (p_once) else $error("clock select changed twice");

    property p_wclk;
        @(posedge clk_i) disable iff (rst_i)
        ##1 wdog_use_bus_clk_o == $past(wdog_clk);
    endproperty
    a_wclk: assert property (p_wclk) else $error("watchdog clock out wrong");

    property p_trig;
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && route.trig_from_timer |=> conv_hw_trigger_o == $past(timer2_ovf_i);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger source wrong");

    property p_spi;
        @(posedge clk_i) disable iff (rst_i)
        route.spi_on_port_b |=> port_b_o[6] == $past(spi_sck_i);
    endproperty
    a_spi: assert property (p_spi) else $error("spi clock misplaced");

    property p_i2c;
        @(posedge clk_i) disable iff (rst_i)
        route.i2c_on_port_a |=> port_a_o[2] == $past(i2c_sda_i);
    endproperty
    a_i2c: assert property (p_i2c) else $error("sda misplaced");

    property p_cap;
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && !route.cmp_to_capture |=> timer2_cap0_o == $past(cap_pin_i);
    endproperty
    a_cap: assert property (p_cap) else $error("capture link wrong");

    property p_idh;
        @(posedge clk_i) disable iff (rst_i)
        state == SOP_IDLE && cyc_i && stb_i && hit_idh |=>
            ack_o && dat_o[7:0] == {4'h0, PART_NUMBER[11:8]};
    endproperty
    a_idh: assert property (p_idh) else $error("id high read wrong");

    property p_rsv;
        @(posedge clk_i) disable iff (rst_i)
        state == SOP_IDLE && cyc_i && stb_i && hit_two |=> dat_o[6:4] == 3'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("unimplemented bits nonzero");

    property p_tmo;
        @(posedge clk_i) disable iff (rst_i)
        ##1 wdog_period_o == ($past(wdog_tmo) ? `SOP_WDOG_LONG_CYCLES : `SOP_WDOG_SHORT_CYCLES);
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout period wrong");

    // a bus cycle taken by the idle slave
    sequence s_take;
        state == SOP_IDLE && cyc_i && stb_i;
    endsequence

    property p_first;
        @(posedge clk_i) disable iff (rst_i)
        wr_lane0 && hit_two && !u_wdog_clk.done |=>
            wdog_clk == $past(dat_i[`SOP_WDOG_CLK_BIT]);
    endproperty
    a_first: assert property (p_first) else $error("first clock select write lost");

    property p_tod;
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && !route.trig_from_timer |=> conv_hw_trigger_o == $past(tod_match_i);
    endproperty
    a_tod: assert property (p_tod) else $error("time-of-day trigger not passed");

    // answers are single-cycle pulses
    property p_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ack_o || err_o |=> !ack_o && !err_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("bus answer held too long");

    property p_err;
        @(posedge clk_i) disable iff (rst_i)
        s_take ##0 !(hit_one || hit_two || hit_idh || hit_idl) |=> err_o && !ack_o;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");

    property p_ack;
        @(posedge clk_i) disable iff (rst_i)
        s_take ##0 (hit_one || hit_two || hit_idh || hit_idl) |=> ack_o && !err_o;
    endproperty
    a_ack: assert property (p_ack) else $error("mapped access not acknowledged");

endmodule : sop_regs
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench for the system options and part id bank
`timescale 1ns/1ps
`default_nettype none
`include "sop_defines.svh"
module tb_top
    import sop_pkg::*;
;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i, pa, pa_fn;
    logic [7:4]  pb, pb_fn;
    logic [31:0] dat_i, dat_o, r;
    logic        tod, ovf, cmp, cap, mosi, sck, ss, sda, scl, wbus, trig, cap0, e;
    logic [17:0] period;
    logic [7:0]  d;
    logic [11:0] pn;
    int          n_errors = 0;
    int          n_checks = 0;
    // bench model of the bank state
    int          m_opt2, m_wlock, m_olock, m_long;

    sop_regs i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .tod_match_i(tod), .timer2_ovf_i(ovf), .cmp_out_i(cmp),
        .cap_pin_i(cap), .spi_mosi_i(mosi), .spi_sck_i(sck), .spi_ss_i(ss),
        .i2c_sda_i(sda), .i2c_scl_i(scl), .wdog_use_bus_clk_o(wbus),
        .wdog_period_o(period), .conv_hw_trigger_o(trig), .timer2_cap0_o(cap0),
        .port_a_o(pa), .port_b_o(pb), .port_a_fn_o(pa_fn), .port_b_fn_o(pb_fn)
    );

    // 50 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task final_report;
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one classic cycle; entered and left right after a rising edge
    task wb(input logic w, input logic [7:0] a, input logic [7:0] wd);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'($urandom), wd}; // upper lanes are ignored, so fill them
        for (k = 0; k < 16; k++)
        begin
            @(posedge clk_i);
            if (ack_o === 1'b1 || err_o === 1'b1)
                break;
        end
        if (k == 16)
        begin
            n_errors++;
            $display("CHECK FAILED %0t bus timeout", $time);
            final_report;
        end
        r = dat_o;
        e = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    // write and update the model
    task mwr(input logic [7:0] a, input logic [7:0] wd);
        wb(1'b1, a, wd);
        if (a == `SOP_OPT_TWO_ADDR)
        begin
            m_opt2 = (m_wlock != 0) ? ((m_opt2 & 'h80) | (wd & 'h0f)) : (wd & 'h8f);
            m_wlock = 1;
        end
        if (a == `SOP_OPT_ONE_ADDR && m_olock == 0)
        begin
            m_long = wd[6];
            m_olock = 1;
        end
    endtask : mwr

    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
        wb(1'b0, a, 8'h00);
        chk(r & mask, exp, "read data");
    endtask : rdchk

    // expected pin ownership and values; two-wire wins on shared pins
    function automatic logic [15:0] mux_exp(input logic spi, input logic i2c);
        logic [3:0] fa, fb, va, vb;
        fa = 4'h0;
        fb = 4'h0;
        va = 4'h0;
        vb = 4'h0;
        if (!spi) begin fa = 4'hf; va = {mosi, 1'b0, sck, ss}; end
        else begin fb = 4'hf; vb = {ss, sck, mosi, 1'b0}; end
        if (!i2c) begin fb[1:0] = 2'b11; vb[1:0] = {scl, sda}; end
        else begin fa[3:2] = 2'b11; va[3:2] = {scl, sda}; end
        return {fa, fb, va & fa, vb & fb};
    endfunction : mux_exp

    task do_reset;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        m_opt2 = 0;
        m_wlock = 0;
        m_olock = 0;
        m_long = 0;
    endtask : do_reset

    // main sequence
    initial
    begin
        {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
        {tod, ovf, cmp, cap, mosi, sck, ss, sda, scl} = '0;
        sel_i = 4'h1;
        pn = `SOP_PART_NUMBER;
        void'($urandom(32'h57bc));
        do_reset;
        rdchk(`SOP_OPT_TWO_ADDR, 32'h0, 32'hff);
        chk(32'(period), 32'(`SOP_WDOG_SHORT_CYCLES), "period");
        wb(1'b0, 8'h10, 8'h00);
        chk(32'(e), 32'h1, "unmapped err");
        // id registers ignore writes; only the part-number bits are checked, not the reserved nibble
        wb(1'b1, `SOP_ID_HIGH_ADDR, 8'($urandom));
        wb(1'b1, `SOP_ID_LOW_ADDR, 8'($urandom));
        rdchk(`SOP_ID_HIGH_ADDR, 32'(pn[11:8]), 32'h0f);
        rdchk(`SOP_ID_LOW_ADDR, 32'(pn[7:0]), 32'hff);
        // write-once bits, twice across a mid-run reset
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 4; i++)
            begin
                d = 8'($urandom);
                d[7] = (i == 0) ? p[0] : !m_opt2[7];
                mwr(`SOP_OPT_TWO_ADDR, d);
                rdchk(`SOP_OPT_TWO_ADDR, 32'(m_opt2), 32'hff);
                repeat (2) @(posedge clk_i);
                chk(32'(wbus), 32'(m_opt2[7]), "wdog clock");
            end
            mwr(`SOP_OPT_ONE_ADDR, {1'b0, !p[0], 6'h0});
            mwr(`SOP_OPT_ONE_ADDR, {1'b0, p[0], 6'h0});
            repeat (2) @(posedge clk_i);
            chk(32'(period), (m_long != 0) ? 32'(`SOP_WDOG_LONG_CYCLES)
                : 32'(`SOP_WDOG_SHORT_CYCLES), "period");
            do_reset;
            rdchk(`SOP_OPT_TWO_ADDR, 32'h0, 32'hff);
        end
        // every setting of the low four bits against random peripheral levels
        for (int i = 0; i < 16; i++)
        begin
            mwr(`SOP_OPT_TWO_ADDR, {4'h0, i[3:0]});
            for (int j = 0; j < 4; j++)
            begin
                {tod, ovf, cmp, cap, mosi, sck, ss, sda, scl} <= 9'($urandom);
                repeat (3) @(posedge clk_i);
                chk(32'(trig), 32'(i[3] ? ovf : tod), "trigger");
                chk(32'(cap0), 32'(i[0] ? cmp : cap), "capture");
                chk(32'({pa_fn, pb_fn, pa & pa_fn, pb & pb_fn}),
                    32'(mux_exp(i[2], i[1])), "pins");
            end
        end
        final_report;
    end
endmodule : tb_top
`default_nettype wire
